// ==== core/afe_cfg_pkg.sv ====
// Purpose: constants for the front end power and clock configuration bank
// Assumes: 8-bit registers, byte-wide register port with 10-bit address
// Notes:   all registers reset to zero
package afe_cfg_pkg;
  // ==========================================================
  // offsets
  localparam logic [9:0] DCC_B_OFF    = 10'h0DB;
  localparam logic [9:0] DCC_A_OFF    = 10'h0F2;
  localparam logic [9:0] PWR_OFF      = 10'h208;
  localparam logic [9:0] TRI_OFF      = 10'h209;
  localparam logic [9:0] IFC_OFF      = 10'h20A;
  localparam logic [9:0] FGAIN_B_OFF  = 10'h237;
  localparam logic [9:0] FGAIN_A_OFF  = 10'h238;
  localparam logic [9:0] CGAIN_OFF    = 10'h239;
  localparam logic [9:0] CLKDIV_OFF   = 10'h23C;
  localparam logic [9:0] PLL_OFF      = 10'h23D;
  localparam logic [9:0] PDSRC_OFF    = 10'h207;
  localparam logic [9:0] RXOVR_OFF    = 10'h33A;
  localparam logic [7:0] REG_RESET    = 8'h00;
  // ==========================================================
  // field positions
  localparam int PWR_TXA_BIT  = 7;
  localparam int PWR_TXB_BIT  = 6;
  localparam int PWR_RXA_BIT  = 5;
  localparam int PWR_RXB_BIT  = 4;
  localparam int PWR_LPC_BIT  = 3;
  localparam int PWR_SGL_BIT  = 2;
  localparam int PDSRC_BIT    = 7;
  localparam int RXOVR_BIT    = 7;
  localparam int TRI_CDAT_BIT = 0;
  localparam int TRI_CCLK_BIT = 1;
  localparam int TRI_LCLK_BIT = 4;
  localparam int TRI_LCHA_BIT = 5;
  localparam int TRI_LCHB_BIT = 6;
  localparam int IFC_SE_BIT   = 5;
  localparam int IFC_LTX_BIT  = 3;
  localparam int IFC_LRX_BIT  = 2;
  localparam int PLL_EN_BIT   = 7;
  localparam int PLL_X4_BIT   = 0;
  localparam int DCC_B_BIT    = 0;
  localparam int DCC_A_BIT    = 3;
  // ==========================================================
  // serial-out pin functions
  typedef enum logic [1:0] {
    SDO_FLOAT  = 2'h0,
    SDO_ANALOG = 2'h1,
    SDO_DOUT   = 2'h2,
    SDO_DIN    = 2'h3
  } sdo_func_t;
endpackage

// ==== core/clk_div_decode.sv ====
// Purpose: decodes a two-bit clock divider code to a division ratio
// Assumes: shared encoding for converter clock dividers
// Notes:   ratio is given as log2 of the factor
`timescale 1ns/1ps
module clk_div_decode
  import afe_cfg_pkg::*;
(
  input  wire logic [1:0] code,
  output wire logic [1:0] log2_ratio
);
  // 00 none, 01 by two, 10 by four, 11 by two
  assign log2_ratio = (code == 2'h2) ? 2'h2 :
                      (code == 2'h0) ? 2'h0 : 2'h1;
endmodule

// ==== core/dac_gain_decode.sv ====
// Purpose: turns fine and coarse gain codes into scale figures
// Assumes: fine code two's complement, coarse code inverted sixteenths
// Notes:   outputs are plain combinational decodes
`timescale 1ns/1ps
module dac_gain_decode
  import afe_cfg_pkg::*;
(
  input  wire logic [7:0] fine_code,
  input  wire logic [3:0] coarse_code,
  output wire logic signed [7:0] fine_offset,
  output wire logic [4:0] coarse_sixteenths
);
  // signed trim: 127 near +4 percent, 128 near -4 percent
  assign fine_offset = $signed(fine_code);
  // output current is (16-k)/16 of full scale
  assign coarse_sixteenths = 5'h10 - {1'b0, coarse_code};
endmodule

// ==== core/afe_power_clock_config_regs.sv ====
// Purpose: power, interface and clock configuration register bank
// Assumes: one clock, synchronous active-low reset, plain register port
// Notes:   read data stands one cycle after the read strobe
// ==========================================================
// What this block does
// - bits 7..4 of 0x208 power down tx A, tx B, rx A, rx B separately
// - source select low routes bit to the pin, high applies it directly
// - with source select clear, the power-down pin is the master control
// - single-channel bit powers down A converters, keeps B, forces SDR
// - 0x209 bits three-state named rx output buffers for half duplex
// - single-ended clock: dac from negative, adc from positive input
// - interfaces default CMOS; 0x20A bit 3 makes tx input LVDS
// - 0x20A bit 2 makes rx output LVDS; software sets rx override too
// - serial-out field selects float, analog test, output or input
// - fine gain codes are two's complement trims of full scale
// - coarse code k gives (16-k)/16 of full scale
// - adc divider: 00 none, 01 by two, 10 by four, 11 by two
// - dac divider uses the same encoding as the adc divider
// - 0x23D bit 7 enables the clock multiplier pll
// - pll select bit set means times four, clear times two
// - dcc enables: 0xDB bit 0 channel B, 0xF2 bit 3 channel A
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module afe_power_clock_config_regs
  import afe_cfg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic [9:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [7:0]        rdata,
  input  wire logic              powerdown_pin,
  output logic                   tx_chan_a_off,
  output logic                   tx_chan_b_off,
  output logic                   rx_chan_a_off,
  output logic                   rx_chan_b_off,
  output logic                   low_power_rx_cmos,
  output logic                   rx_sdr_forced,
  output logic                   cmos_data_tristate,
  output logic                   cmos_clock_tristate,
  output logic                   lvds_clock_tristate,
  output logic                   lvds_chan_a_tristate,
  output logic                   lvds_chan_b_tristate,
  output logic                   single_ended_clock_sel,
  output logic                   dac_clk_from_negative,
  output logic                   diff_clock_buffer_on,
  output logic                   tx_lvds_mode,
  output logic                   rx_lvds_mode,
  output logic                   rx_master_override,
  output sdo_func_t              serial_out_pin_function,
  output logic                   sdo_drive_en,
  output logic                   sdo_input_en,
  output logic signed [7:0]      dac_a_fine_offset,
  output logic signed [7:0]      dac_b_fine_offset,
  output logic      [4:0]        dac_a_coarse_sixteenths,
  output logic      [4:0]        dac_b_coarse_sixteenths,
  output logic      [1:0]        cmos_drive_strength,
  output logic      [1:0]        adc_div_log2,
  output logic      [1:0]        dac_div_log2,
  output logic                   pll_enable,
  output logic                   pll_times_four_select,
  output logic      [1:0]        pll_range_select,
  output logic                   duty_correct_chan_a_on,
  output logic                   duty_correct_chan_b_on
);
  // ==========================================================
  // storage
  logic [7:0] pdsrc_reg, pwr_reg, tri_reg, ifc_reg, fga_reg, fgb_reg;
  logic [7:0] cg_reg, div_reg, pll_reg, dcca_reg, dccb_reg, ovr_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic       pin_meta_reg, pin_sync_reg;
  logic       pd_src_reg;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
    hit = (a == off);
  endfunction

  wire we = clk_en && wr_stb;

  // ==========================================================
  // writes; reset zeroes every register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pdsrc_reg <= REG_RESET;
      pwr_reg   <= REG_RESET;
      tri_reg   <= REG_RESET;
      ifc_reg   <= REG_RESET;
      fga_reg   <= REG_RESET;
      fgb_reg   <= REG_RESET;
      cg_reg    <= REG_RESET;
      div_reg   <= REG_RESET;
      pll_reg   <= REG_RESET;
      dcca_reg  <= REG_RESET;
      dccb_reg  <= REG_RESET;
      ovr_reg   <= REG_RESET;
    end else if (we) begin
      if (hit(addr, PDSRC_OFF))   pdsrc_reg <= wdata;
      if (hit(addr, PWR_OFF))     pwr_reg   <= wdata;
      if (hit(addr, TRI_OFF))     tri_reg   <= wdata;
      if (hit(addr, IFC_OFF))     ifc_reg   <= wdata;
      if (hit(addr, FGAIN_A_OFF)) fga_reg   <= wdata;
      if (hit(addr, FGAIN_B_OFF)) fgb_reg   <= wdata;
      if (hit(addr, CGAIN_OFF))   cg_reg    <= wdata;
      if (hit(addr, CLKDIV_OFF))  div_reg   <= wdata;
      if (hit(addr, PLL_OFF))     pll_reg   <= wdata;
      if (hit(addr, DCC_A_OFF))   dcca_reg  <= wdata;
      if (hit(addr, DCC_B_OFF))   dccb_reg  <= wdata;
      if (hit(addr, RXOVR_OFF))   ovr_reg   <= wdata;
    end
  end

  // ==========================================================
  // readback: stored value unchanged, unmapped reads zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (addr)
      PDSRC_OFF:   rdata_next = pdsrc_reg;
      PWR_OFF:     rdata_next = pwr_reg;
      TRI_OFF:     rdata_next = tri_reg;
      IFC_OFF:     rdata_next = ifc_reg;
      FGAIN_A_OFF: rdata_next = fga_reg;
      FGAIN_B_OFF: rdata_next = fgb_reg;
      CGAIN_OFF:   rdata_next = cg_reg;
      CLKDIV_OFF:  rdata_next = div_reg;
      PLL_OFF:     rdata_next = pll_reg;
      DCC_A_OFF:   rdata_next = dcca_reg;
      DCC_B_OFF:   rdata_next = dccb_reg;
      RXOVR_OFF:   rdata_next = ovr_reg;
      default:     rdata_next = 8'h00;
    endcase
  end

  // read data held only the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n)    rdata_reg <= 8'h00;
    else if (clk_en) rdata_reg <= rd_stb ? rdata_next : 8'h00;
  end
  assign rdata = rdata_reg;

  // ==========================================================
  // power-down pin crosses in through two flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pd_src_reg   <= 1'b0;
    end else if (clk_en) begin
      pin_meta_reg <= powerdown_pin;
      pin_sync_reg <= pin_meta_reg;
      pd_src_reg   <= pdsrc_reg[PDSRC_BIT];
    end
  end

  // select high: bit acts directly; low: pin is master, bit arms it
  wire pd_gate = pd_src_reg ? 1'b1 : pin_sync_reg;
  wire single  = pwr_reg[PWR_SGL_BIT];

  assign tx_chan_a_off = (pwr_reg[PWR_TXA_BIT] & pd_gate) | single;
  assign tx_chan_b_off = pwr_reg[PWR_TXB_BIT] & pd_gate;
  assign rx_chan_a_off = (pwr_reg[PWR_RXA_BIT] & pd_gate) | single;
  assign rx_chan_b_off = pwr_reg[PWR_RXB_BIT] & pd_gate;
  assign rx_sdr_forced = single;
  // honoured as written; only meaningful for CMOS below 40 MSPS
  assign low_power_rx_cmos = pwr_reg[PWR_LPC_BIT];

  // ==========================================================
  // output buffer three-state controls
  assign cmos_data_tristate   = tri_reg[TRI_CDAT_BIT];
  assign cmos_clock_tristate  = tri_reg[TRI_CCLK_BIT];
  assign lvds_clock_tristate  = tri_reg[TRI_LCLK_BIT];
  assign lvds_chan_a_tristate = tri_reg[TRI_LCHA_BIT];
  assign lvds_chan_b_tristate = tri_reg[TRI_LCHB_BIT];

  // ==========================================================
  // clock input and interface selection
  assign single_ended_clock_sel = ifc_reg[IFC_SE_BIT];
  assign dac_clk_from_negative  = ifc_reg[IFC_SE_BIT];
  assign diff_clock_buffer_on   = ~ifc_reg[IFC_SE_BIT];
  assign tx_lvds_mode           = ifc_reg[IFC_LTX_BIT];
  assign rx_lvds_mode           = ifc_reg[IFC_LRX_BIT];
  // full LVDS setup also needs this override written
  assign rx_master_override     = ovr_reg[RXOVR_BIT];
  assign serial_out_pin_function = sdo_func_t'(ifc_reg[1:0]);
  assign sdo_drive_en = (ifc_reg[1:0] == SDO_DOUT);
  assign sdo_input_en = (ifc_reg[1:0] == SDO_DIN);

  // ==========================================================
  // dac gain decoding
  dac_gain_decode u_gain_a (
    .fine_code         (fga_reg),
    .coarse_code       (cg_reg[7:4]),
    .fine_offset       (dac_a_fine_offset),
    .coarse_sixteenths (dac_a_coarse_sixteenths)
  );
  dac_gain_decode u_gain_b (
    .fine_code         (fgb_reg),
    .coarse_code       (cg_reg[3:0]),
    .fine_offset       (dac_b_fine_offset),
    .coarse_sixteenths (dac_b_coarse_sixteenths)
  );

  // ==========================================================
  // clocking
  // strength is software's call; raises SNR risk above 90 MSPS
  assign cmos_drive_strength = div_reg[7:6];
  clk_div_decode u_div_adc (
    .code       (div_reg[4:3]),
    .log2_ratio (adc_div_log2)
  );
  clk_div_decode u_div_dac (
    .code       (div_reg[2:1]),
    .log2_ratio (dac_div_log2)
  );
  assign pll_enable            = pll_reg[PLL_EN_BIT];
  assign pll_times_four_select = pll_reg[PLL_X4_BIT];
  // range is not checked against rate; software must pick it
  assign pll_range_select      = pll_reg[3:2];
  assign duty_correct_chan_b_on = dccb_reg[DCC_B_BIT];
  assign duty_correct_chan_a_on = dcca_reg[DCC_A_BIT];

  // ==========================================================
  // checks
  sequence wr_s(logic [9:0] off);
    clk_en && wr_stb && addr == off;
  endsequence

  readback_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_stb && clk_en |=> rdata == $past(rdata_next))
    else $error("readback mismatch");
  idle_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    !rd_stb && clk_en |=> rdata == 8'h00)
    else $error("read data not zero when idle");
  single_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(PWR_OFF) && wdata[PWR_SGL_BIT] |=>
      tx_chan_a_off && rx_chan_a_off && rx_sdr_forced)
    else $error("single channel not applied");
  direct_pd_a: assert property (@(posedge clk) disable iff (!reset_n)
    pd_src_reg && !single |-> tx_chan_b_off == pwr_reg[PWR_TXB_BIT])
    else $error("direct power-down mismatch");
  pin_master_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pd_src_reg && !pin_sync_reg |-> !rx_chan_b_off && !tx_chan_b_off)
    else $error("pin did not gate power-down");
  se_clock_a: assert property (@(posedge clk) disable iff (!reset_n)
    diff_clock_buffer_on != dac_clk_from_negative)
    else $error("clock buffer select wrong");
  sdo_func_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(sdo_drive_en && sdo_input_en))
    else $error("serial out both drive and input");
  div_four_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(CLKDIV_OFF) && wdata[4:3] == 2'h2 |=> adc_div_log2 == 2'h2)
    else $error("adc divide by four missing");
  coarse_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(CGAIN_OFF) |=> dac_b_coarse_sixteenths == 5'h10 - $past(wdata[3:0]))
    else $error("coarse gain decode wrong");
  pll_x4_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(PLL_OFF) |=> pll_times_four_select == $past(wdata[PLL_X4_BIT])
      && pll_enable == $past(wdata[PLL_EN_BIT]))
    else $error("pll control not stored");

  // ==========================================================
  // channel, pin and decode checks
  sequence pin_in_s;
    clk_en && powerdown_pin ##1 clk_en;
  endsequence

  rx_b_pd_a: assert property (@(posedge clk) disable iff (!reset_n)
    pd_src_reg && pwr_reg[PWR_RXB_BIT] |-> rx_chan_b_off)
    else $error("rx channel B not powered down");

  tx_a_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pwr_reg[PWR_TXA_BIT] && !single |-> !tx_chan_a_off)
    else $error("tx channel A off without its bit");

  pin_arm_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pd_src_reg && pin_sync_reg && pwr_reg[PWR_RXA_BIT] |-> rx_chan_a_off)
    else $error("armed bit ignored the pin");

  pin_sync_a: assert property (@(posedge clk) disable iff (!reset_n)
    pin_in_s |=> pin_sync_reg)
    else $error("pin did not pass the synchroniser");

  keep_b_a: assert property (@(posedge clk) disable iff (!reset_n)
    single && !pwr_reg[PWR_TXB_BIT] && !pwr_reg[PWR_RXB_BIT] |->
      !tx_chan_b_off && !rx_chan_b_off)
    else $error("single channel powered down B");

  tri_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(TRI_OFF) |=> cmos_data_tristate == $past(wdata[TRI_CDAT_BIT])
      && lvds_chan_b_tristate == $past(wdata[TRI_LCHB_BIT]))
    else $error("three-state control not stored");

  se_clk_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(IFC_OFF) |=> single_ended_clock_sel == $past(wdata[IFC_SE_BIT]))
    else $error("single-ended clock select not stored");

  lvds_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(IFC_OFF) |=> tx_lvds_mode == $past(wdata[IFC_LTX_BIT])
      && rx_lvds_mode == $past(wdata[IFC_LRX_BIT]))
    else $error("interface mode not stored");

  rx_ovr_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(RXOVR_OFF) |=> rx_master_override == $past(wdata[RXOVR_BIT]))
    else $error("rx override not stored");

  sdo_out_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(IFC_OFF) && wdata[1:0] == 2'h2 |=> sdo_drive_en && !sdo_input_en)
    else $error("serial out not driving");

  sdo_float_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(IFC_OFF) && wdata[1:0] == 2'h0 |=> !sdo_drive_en && !sdo_input_en)
    else $error("serial out not floating");

  a_fine_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(FGAIN_A_OFF) |=> dac_a_fine_offset == $signed($past(wdata)))
    else $error("channel A fine gain wrong");

  b_fine_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(FGAIN_B_OFF) |=> dac_b_fine_offset == $signed($past(wdata)))
    else $error("channel B fine gain wrong");

  coarse_hi_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(CGAIN_OFF) |=>
      dac_a_coarse_sixteenths == 5'h10 - $past(wdata[7:4]))
    else $error("channel A coarse gain wrong");

  dac_div_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(CLKDIV_OFF) && wdata[2:1] == 2'h3 |=> dac_div_log2 == 2'h1)
    else $error("dac divide code three not by two");

  dcc_hi_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(DCC_A_OFF) |=> duty_correct_chan_a_on == $past(wdata[DCC_A_BIT]))
    else $error("channel A duty correction not stored");

  dcc_lo_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_s(DCC_B_OFF) |=> duty_correct_chan_b_on == $past(wdata[DCC_B_BIT]))
    else $error("channel B duty correction not stored");

  freeze_a: assert property (@(posedge clk) disable iff (!reset_n)
    !clk_en |=> $stable(pwr_reg) && $stable(rdata))
    else $error("state moved while clock enable low");

  unmapped_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_stb && clk_en && addr == 10'h100 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ==== dv/afe_power_clock_config_regs_bench.sv ====
// Purpose: self-checking bench for the power and clock configuration bank
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   expectations come from a shadow copy of every register
`timescale 1ns/1ps
module afe_power_clock_config_regs_bench;
  import afe_cfg_pkg::*;
  typedef struct packed {logic [9:0] a; logic [7:0] d;} row_t;
  localparam logic [9:0] MAP [12] = '{DCC_B_OFF, DCC_A_OFF, PWR_OFF,
    TRI_OFF, IFC_OFF, FGAIN_B_OFF, FGAIN_A_OFF, CGAIN_OFF, CLKDIV_OFF,
    PLL_OFF, PDSRC_OFF, RXOVR_OFF};
  localparam row_t ROWS [30] = '{'{PWR_OFF, 8'hF0}, '{PDSRC_OFF, 8'h80},
    '{PWR_OFF, 8'h50}, '{PWR_OFF, 8'h04}, '{PWR_OFF, 8'h08},
    '{TRI_OFF, 8'h73}, '{TRI_OFF, 8'h00}, '{IFC_OFF, 8'h20},
    '{IFC_OFF, 8'h08}, '{IFC_OFF, 8'h04}, '{RXOVR_OFF, 8'h80},
    '{IFC_OFF, 8'h01}, '{IFC_OFF, 8'h02}, '{IFC_OFF, 8'h03},
    '{IFC_OFF, 8'h00}, '{FGAIN_B_OFF, 8'h7F}, '{FGAIN_A_OFF, 8'h80},
    '{CGAIN_OFF, 8'h0F}, '{CGAIN_OFF, 8'hF0}, '{CGAIN_OFF, 8'h5A},
    '{CLKDIV_OFF, 8'h8A}, '{CLKDIV_OFF, 8'h54}, '{CLKDIV_OFF, 8'hDE},
    '{PLL_OFF, 8'h80}, '{PLL_OFF, 8'h8D}, '{PLL_OFF, 8'h08},
    '{DCC_B_OFF, 8'h01}, '{DCC_A_OFF, 8'h08}, '{10'h100, 8'hFF},
    '{PDSRC_OFF, 8'h00}};
  logic clk, reset_n, clk_en, wr_stb, rd_stb, powerdown_pin;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, dac_a_fine_offset, dac_b_fine_offset, v;
  logic tx_chan_a_off, tx_chan_b_off, rx_chan_a_off, rx_chan_b_off;
  logic low_power_rx_cmos, rx_sdr_forced, cmos_data_tristate;
  logic cmos_clock_tristate, lvds_clock_tristate, lvds_chan_a_tristate;
  logic lvds_chan_b_tristate, single_ended_clock_sel, dac_clk_from_negative;
  logic diff_clock_buffer_on, tx_lvds_mode, rx_lvds_mode, rx_master_override;
  logic sdo_drive_en, sdo_input_en, pll_enable, pll_times_four_select;
  logic duty_correct_chan_a_on, duty_correct_chan_b_on;
  logic [4:0] dac_a_coarse_sixteenths, dac_b_coarse_sixteenths;
  logic [1:0] cmos_drive_strength, adc_div_log2, dac_div_log2;
  logic [1:0] pll_range_select;
  sdo_func_t serial_out_pin_function;
  logic [58:0] obs;
  logic [7:0] sh [0:1023];
  logic pin_m;
  int bad_count, tests_run;
  afe_power_clock_config_regs dut (.clk, .reset_n, .clk_en, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .powerdown_pin, .tx_chan_a_off, .tx_chan_b_off,
    .rx_chan_a_off, .rx_chan_b_off, .low_power_rx_cmos, .rx_sdr_forced,
    .cmos_data_tristate, .cmos_clock_tristate, .lvds_clock_tristate,
    .lvds_chan_a_tristate, .lvds_chan_b_tristate, .single_ended_clock_sel,
    .dac_clk_from_negative, .diff_clock_buffer_on, .tx_lvds_mode,
    .rx_lvds_mode, .rx_master_override, .serial_out_pin_function,
    .sdo_drive_en, .sdo_input_en, .dac_a_fine_offset, .dac_b_fine_offset,
    .dac_a_coarse_sixteenths, .dac_b_coarse_sixteenths, .cmos_drive_strength,
    .adc_div_log2, .dac_div_log2, .pll_enable, .pll_times_four_select,
    .pll_range_select, .duty_correct_chan_a_on, .duty_correct_chan_b_on);
  assign obs = {tx_chan_a_off, tx_chan_b_off, rx_chan_a_off, rx_chan_b_off,
    low_power_rx_cmos, rx_sdr_forced, cmos_data_tristate, cmos_clock_tristate,
    lvds_clock_tristate, lvds_chan_a_tristate, lvds_chan_b_tristate,
    single_ended_clock_sel, dac_clk_from_negative, diff_clock_buffer_on,
    tx_lvds_mode, rx_lvds_mode, rx_master_override, serial_out_pin_function,
    sdo_drive_en, sdo_input_en, dac_a_fine_offset, dac_b_fine_offset,
    dac_a_coarse_sixteenths, dac_b_coarse_sixteenths, cmos_drive_strength,
    adc_div_log2, dac_div_log2, pll_enable, pll_times_four_select,
    pll_range_select, duty_correct_chan_a_on, duty_correct_chan_b_on};
  // ==========================================================
  // expectation model
  function automatic logic [1:0] dv(logic [1:0] c);
    return (c == 2'h3) ? 2'h1 : c;
  endfunction
  function automatic logic [58:0] exp_obs();
    logic [7:0] p, t, f, c, k, l;
    logic e;
    p = sh[PWR_OFF]; t = sh[TRI_OFF]; f = sh[IFC_OFF];
    c = sh[CGAIN_OFF]; k = sh[CLKDIV_OFF]; l = sh[PLL_OFF];
    // pin acts as master unless the source select is set
    e = sh[PDSRC_OFF][PDSRC_BIT] | pin_m;
    return {p[7] & e | p[2], p[6] & e, p[5] & e | p[2], p[4] & e, p[3], p[2],
      t[0], t[1], t[4], t[5], t[6], f[5], f[5], ~f[5], f[3], f[2],
      sh[RXOVR_OFF][RXOVR_BIT], f[1:0], f[1:0] == 2'h2, f[1:0] == 2'h3,
      sh[FGAIN_A_OFF], sh[FGAIN_B_OFF], 5'h10 - {1'b0, c[7:4]},
      5'h10 - {1'b0, c[3:0]}, k[7:6], dv(k[4:3]), dv(k[2:1]), l[7], l[0],
      l[3:2], sh[DCC_A_OFF][DCC_A_BIT], sh[DCC_B_OFF][DCC_B_BIT]};
  endfunction
  function automatic logic [7:0] exp_rd(logic [9:0] a);
    foreach (MAP[i]) if (MAP[i] == a) return sh[a];
    return 8'h00;
  endfunction
  // ==========================================================
  // bus tasks and compares
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_obs(input logic [58:0] g, input logic [58:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_stb <= 1'b1; rd_stb <= 1'b0;
    if (clk_en) sh[a] = d;
  endtask
  task automatic idle();
    @(posedge clk);
    wr_stb <= 1'b0; rd_stb <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] r);
    @(posedge clk);
    addr <= a; rd_stb <= 1'b1; wr_stb <= 1'b0;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 r = rdata;
    @(posedge clk);
    #1 chk8(rdata, 8'h00);
  endtask
  task automatic check_all();
    foreach (MAP[i]) begin
      rd(MAP[i], v);
      chk8(v, exp_rd(MAP[i]));
    end
    chk_obs(obs, exp_obs());
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    reset_n = 1'b0; clk_en = 1'b1; addr = 10'h000; wdata = 8'h00;
    wr_stb = 1'b0; rd_stb = 1'b0; powerdown_pin = 1'b0; pin_m = 1'b0;
    bad_count = 0; tests_run = 0;
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    check_all();
    $display("reset values done");
    // two edges: the source select passes one extra flop
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      idle();
      idle();
      #1 chk_obs(obs, exp_obs());
      rd(ROWS[i].a, v);
      chk8(v, exp_rd(ROWS[i].a));
    end
    $display("register table done");
    wr(PWR_OFF, 8'h08);
    wr(CLKDIV_OFF, 8'h80);
    wr(PLL_OFF, 8'h85);
    idle();
    #1 chk_obs(obs, exp_obs());
    wr(PWR_OFF, 8'hF0);
    idle();
    @(posedge clk);
    powerdown_pin <= 1'b1;
    @(posedge clk);
    #1 chk_obs(obs, exp_obs());
    @(posedge clk);
    #1 pin_m = 1'b1;
    chk_obs(obs, exp_obs());
    @(posedge clk);
    powerdown_pin <= 1'b0;
    repeat (3) idle();
    pin_m = 1'b0;
    wr(PWR_OFF, 8'h04);
    idle();
    #1 chk_obs(obs, exp_obs());
    $display("power pin done");
    wr(FGAIN_A_OFF, 8'h11);
    wr(FGAIN_B_OFF, 8'h22);
    @(posedge clk);
    addr <= FGAIN_A_OFF; wr_stb <= 1'b0; rd_stb <= 1'b1;
    @(posedge clk);
    addr <= FGAIN_B_OFF;
    #1 chk8(rdata, 8'h11);
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk8(rdata, 8'h22);
    $display("back to back done");
    @(posedge clk);
    clk_en <= 1'b0;
    wr(CGAIN_OFF, 8'hFF);
    idle();
    @(posedge clk);
    clk_en <= 1'b1;
    check_all();
    $display("clock enable hold done");
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    foreach (sh[i]) sh[i] = 8'h00;
    check_all();
    $display("second reset done");
    give_verdict();
  end
endmodule
